//--- verilog/evp_pkg.sv
// package of constants and types for the exception vector and priority logic
package evp_pkg;
   localparam int NUM_EXC   = 60;
   localparam int EXC_W     = 6;
   localparam int IRQ_BASE  = 16;
   localparam int NUM_IRQ   = 44;
   localparam int PRI_W     = 3;
   localparam int RANK_W    = 4;

   localparam logic [EXC_W-1:0] EXC_RESET = 6'h01;
   localparam logic [EXC_W-1:0] EXC_NMI   = 6'h02;
   localparam logic [EXC_W-1:0] EXC_HARD  = 6'h03;
   localparam logic [EXC_W-1:0] EXC_NONE  = 6'h00;

   // rank = priority + 3, so reset -3 -> 0, nmi -2 -> 1, hard fault -1 -> 2, level p -> p+3
   localparam logic [RANK_W-1:0] RANK_RESET = 4'h0;
   localparam logic [RANK_W-1:0] RANK_NMI   = 4'h1;
   localparam logic [RANK_W-1:0] RANK_HARD  = 4'h2;
   localparam logic [RANK_W-1:0] RANK_OFS   = 4'h3;
   localparam logic [RANK_W-1:0] RANK_IDLE  = 4'hF;
   localparam logic [PRI_W-1:0]  PRI_RESET_VAL = 3'h0;

   localparam logic [31:0] TABLE_RESET_BASE = 32'h0000_0000;
   localparam logic [31:0] TABLE_MIN_BASE   = 32'h0000_0100;
   localparam logic [31:0] TABLE_MAX_BASE   = 32'h3FFF_FF00;
   localparam int          BASE_LSB         = 8;
   localparam int          ENTRY_SHIFT      = 2;

   // vector numbers that have a source (system ones and wired interrupts)
   localparam logic [NUM_EXC-1:0] EXC_IMPL = 60'hC98_FFFF_C1FF_D87E;

   typedef enum logic [1:0] {
      EXC_INACTIVE   = 2'b00,
      EXC_PENDING    = 2'b01,
      EXC_ACTIVE     = 2'b10,
      EXC_ACT_PEND   = 2'b11
   } evp_state_t;

   typedef struct packed {
      logic             valid;
      logic [EXC_W-1:0] num;
      logic [RANK_W-1:0] rank;
   } evp_cand_t;

   typedef struct packed {
      logic        wr;
      logic [31:0] base;
   } evp_reloc_t;
endpackage

//--- verilog/evp_pri_mem.sv
// small memory holding the programmable priority of each exception number
`timescale 1ns/100ps
module evp_pri_mem
   import evp_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // write port
   input  wire logic                 wrEn,
   input  wire logic [EXC_W-1:0]     wrNum,
   input  wire logic [PRI_W-1:0]     wrPri,
   // whole table, registered
   output logic [NUM_EXC*PRI_W-1:0]  priTable
);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         priTable <= '0;
      end else if (wrEn && (32'(wrNum) < NUM_EXC)) begin
         priTable[wrNum*PRI_W +: PRI_W] <= wrPri;
      end
   end
endmodule

//--- verilog/evp_exception_vector_priority.sv
// exception vectoring, priority arbitration and preemption decision
`timescale 1ns/100ps
module evp_exception_vector_priority
   import evp_pkg::*;
(
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst,
   // exception requests, one pulse or level per vector number
   input  wire logic [NUM_EXC-1:0]  excReq,
   // priority programming
   input  wire logic                priWr,
   input  wire logic [EXC_W-1:0]    priNum,
   input  wire logic [PRI_W-1:0]    priVal,
   // table relocation
   input  wire evp_reloc_t          relocReq,
   input  wire logic                privileged,
   // core handshake
   input  wire logic                entryAck,
   input  wire logic                handlerDone,
   // results
   output logic                     takeValid,
   output logic [EXC_W-1:0]         takeNum,
   output logic [31:0]              vectorAddr,
   output logic [31:0]              vectorBase,
   output logic [EXC_W-1:0]         runningNum,
   output logic [RANK_W-1:0]        runningRank,
   output logic [NUM_EXC-1:0]       pendingMask,
   output logic [NUM_EXC-1:0]       activeMask
);
   logic [NUM_EXC*PRI_W-1:0]  priTable;
   logic [31-BASE_LSB:0]      baseHi;
   logic [NUM_EXC-1:0]        pend;
   logic [NUM_EXC-1:0]        act;
   logic [RANK_W-1:0]         stackRank [NUM_EXC];
   evp_cand_t                 best;
   logic [31:0]               next_vectorAddr;
   logic                      preempt;
   logic [EXC_W-1:0]          curNum;
   logic [RANK_W-1:0]         curRank;

   // rank of a vector number: fixed for reset, nmi, hard fault; else level + offset
   function automatic logic [RANK_W-1:0] rankOf(input logic [EXC_W-1:0] n,
                                                  input logic [NUM_EXC*PRI_W-1:0] tbl);
      logic [RANK_W-1:0] r;
      r = RANK_OFS + RANK_W'(tbl[n*PRI_W +: PRI_W]);
      case (n)
         EXC_RESET: r = RANK_RESET;
         EXC_NMI:   r = RANK_NMI;
         EXC_HARD:  r = RANK_HARD;
         default:   r = r;
      endcase
      return r;
   endfunction

   function automatic evp_state_t stateOf(input logic p, input logic a);
      return evp_state_t'({a, p});
   endfunction

   evp_pri_mem uPriMem (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .wrEn     (priWr),
      .wrNum    (priNum),
      .wrPri    (priVal),
      .priTable (priTable)
   );

   // relocation: privileged, in range writes only, any alignment; low bits dropped
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         baseHi <= TABLE_RESET_BASE[31:BASE_LSB];
      end else if (relocReq.wr && privileged
                   && relocReq.base >= TABLE_MIN_BASE
                   && relocReq.base <= TABLE_MAX_BASE) begin
         baseHi <= relocReq.base[31:BASE_LSB];
      end
   end
   assign vectorBase = {baseHi, {BASE_LSB{1'b0}}};

   // arbitration: lowest rank wins, scan from high number so low number wins ties
   always_comb begin
      best = '{valid: 1'b0, num: EXC_NONE, rank: RANK_IDLE};
      for (int i = NUM_EXC - 1; i >= 0; i--) begin
         if (pend[i] && rankOf(EXC_W'(i), priTable) <= best.rank) begin
            best.valid = 1'b1;
            best.num   = EXC_W'(i);
            best.rank  = rankOf(EXC_W'(i), priTable);
         end
      end
   end

   // nested handler stack is tracked by the rank each active handler runs at
   always_comb begin
      curNum  = EXC_NONE;
      curRank = RANK_IDLE;
      for (int i = 0; i < NUM_EXC; i++) begin
         if (act[i] && stackRank[i] < curRank) begin
            curNum  = EXC_W'(i);
            curRank = stackRank[i];
         end
      end
   end

   // strictly smaller rank only; equal rank waits as pending
   assign preempt   = best.valid && (best.rank < curRank);
   assign takeValid = preempt;
   assign takeNum   = best.num;

   // base plus four bytes per vector; entry zero is the stack pointer value
   assign next_vectorAddr = vectorBase + (32'(best.num) << ENTRY_SHIFT);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         vectorAddr <= TABLE_RESET_BASE;
      end else begin
         vectorAddr <= next_vectorAddr;
      end
   end

   // per-exception pending and active state
   genvar g;
   generate
      for (g = 0; g < NUM_EXC; g++) begin : gExc
         logic taken;
         logic done;
         assign taken = entryAck && preempt && (best.num == EXC_W'(g));
         assign done  = handlerDone && (curNum == EXC_W'(g)) && act[g];
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               pend[g] <= 1'b0;
            end else if (!EXC_IMPL[g]) begin
               pend[g] <= 1'b0;
            end else if (excReq[g]) begin
               pend[g] <= 1'b1;
            end else if (taken) begin
               pend[g] <= 1'b0;
            end
         end
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               act[g]       <= 1'b0;
               stackRank[g] <= RANK_IDLE;
            end else if (taken) begin
               act[g]       <= 1'b1;
               stackRank[g] <= best.rank;
            end else if (done) begin
               act[g]       <= 1'b0;
               stackRank[g] <= RANK_IDLE;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         runningNum  <= EXC_NONE;
         runningRank <= RANK_IDLE;
         pendingMask <= '0;
         activeMask  <= '0;
      end else begin
         runningNum  <= curNum;
         runningRank <= curRank;
         pendingMask <= pend;
         activeMask  <= act;
      end
   end

   // state decode kept for observation of the first interrupt source (number IRQ_BASE)
   evp_state_t firstState;
   assign firstState = stateOf(pend[IRQ_BASE], act[IRQ_BASE]);
endmodule

//--- dv/evp_monitor.sv
// port checker for the exception vector and priority logic
`timescale 1ns/100ps
module evp_monitor
   import evp_pkg::*;
(
   // clock and reset
   input wire logic               clk_sys,
   input wire logic               rst,
   // requests and handshake
   input wire logic [NUM_EXC-1:0] excReq,
   input wire logic               entryAck,
   // results
   input wire logic               takeValid,
   input wire logic [EXC_W-1:0]   takeNum,
   input wire logic [31:0]        vectorAddr,
   input wire logic [31:0]        vectorBase,
   input wire logic [RANK_W-1:0]  runningRank,
   input wire logic [NUM_EXC-1:0] pendingMask,
   input wire logic [NUM_EXC-1:0] activeMask
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_base_reset:
      assert property ($fell(rst) |-> vectorBase == TABLE_RESET_BASE && runningRank == RANK_IDLE)
      else $error("bad state after reset");
   a_base_align: assert property (vectorBase[BASE_LSB-1:0] == 8'h00)
      else $error("base not aligned");
   a_unused_idle: assert property ((pendingMask & ~EXC_IMPL) == '0)
      else $error("unassigned number pending");
   a_addr_calc: assert property (takeValid |=> vectorAddr == $past(vectorBase) + {$past(takeNum), 2'b00})
      else $error("wrong fetch address");
   a_hard_preempt: assert property (takeValid && takeNum == EXC_HARD |-> runningRank > RANK_HARD)
      else $error("hard fault offered over equal rank");
   a_nmi_wins:
      assert property (excReq[EXC_NMI] && !excReq[EXC_RESET] && !entryAck && runningRank > RANK_NMI
         |=> takeValid && takeNum == EXC_NMI)
      else $error("nmi not offered");
   a_take_stands: assert property (takeValid && !entryAck |=> takeValid)
      else $error("offer withdrawn");
   a_ack_active: assert property (takeValid && entryAck |-> ##2 activeMask[$past(takeNum, 2)])
      else $error("accepted exception not active");
endmodule
bind evp_exception_vector_priority evp_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .excReq(excReq),
   .entryAck(entryAck), .takeValid(takeValid), .takeNum(takeNum), .vectorAddr(vectorAddr),
   .vectorBase(vectorBase), .runningRank(runningRank), .pendingMask(pendingMask), .activeMask(activeMask));

//--- dv/evp_core_model.sv
// core model that accepts an offered exception after a set number of cycles
`timescale 1ns/100ps
module evp_core_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // handshake
   input  wire logic       takeValid,
   input  wire logic [3:0] lat,
   input  wire logic [31:0] vectorAddr,
   output logic            entryAck
);
   int cnt = 0;
   // table word the core would load: software always sets bit zero
   logic [31:0] handlerWord = 32'h0000_0000;
   initial entryAck = 1'b0;
   // a one-cycle gap after each accept, so an offer is never taken twice
   always @(posedge clk_sys) begin
      #1;
      entryAck = !rst && takeValid && !entryAck && cnt >= lat;
      cnt = (rst || !takeValid || entryAck) ? 0 : cnt + 1;
      if (entryAck) handlerWord = vectorAddr | 32'h0000_0001;
   end
endmodule

//--- dv/evp_exception_vector_priority_tb_top.sv
// self-checking bench for the exception vector and priority logic
`timescale 1ns/100ps
module evp_exception_vector_priority_tb_top
   import evp_pkg::*;
;
   typedef struct packed {logic [5:0] a, b; logic [2:0] pa, pb; logic [5:0] win;} evp_row_t;
   evp_row_t rows [6] = '{'{6'h10, 6'h11, 3'h0, 3'h0, 6'h10}, '{6'h10, 6'h11, 3'h5, 3'h2, 6'h11},
      '{6'h02, 6'h10, 3'h7, 3'h0, 6'h02}, '{6'h04, 6'h03, 3'h0, 3'h7, 6'h03},
      '{6'h07, 6'h3B, 3'h3, 3'h7, 6'h3B}, '{6'h0F, 6'h0E, 3'h4, 3'h4, 6'h0E}};
   logic [31:0] rbase [5] = '{32'h0000_1000, 32'h0000_0080, 32'h4000_0000, 32'h0000_1234, 32'h3FFF_FF00};
   logic [31:0] rexp  [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_1200, 32'h3FFF_FF00};
   logic clk_sys = 0, rst = 1, priWr = 0, privileged = 0, handlerDone = 0, entryAck, takeValid;
   logic [NUM_EXC-1:0] excReq = '0, pendingMask, activeMask;
   logic [EXC_W-1:0]   priNum = '0, takeNum, runningNum;
   logic [PRI_W-1:0]   priVal = '0;
   logic [RANK_W-1:0]  runningRank;
   logic [31:0]        vectorAddr, vectorBase;
   logic [3:0]         lat = 4'h1;
   evp_reloc_t         relocReq = '0;
   int                 failCount = 0, comparisons = 0;
   evp_exception_vector_priority dut (.clk_sys(clk_sys), .rst(rst), .excReq(excReq), .priWr(priWr),
      .priNum(priNum), .priVal(priVal), .relocReq(relocReq), .privileged(privileged), .entryAck(entryAck),
      .handlerDone(handlerDone), .takeValid(takeValid), .takeNum(takeNum), .vectorAddr(vectorAddr),
      .vectorBase(vectorBase), .runningNum(runningNum), .runningRank(runningRank), .pendingMask(pendingMask),
      .activeMask(activeMask));
   evp_core_model core (.clk_sys(clk_sys), .rst(rst), .takeValid(takeValid), .lat(lat),
      .vectorAddr(vectorAddr), .entryAck(entryAck));
   always #10 clk_sys = ~clk_sys;
   task automatic tick;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      comparisons++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic doReset;
      rst = 1'b1;
      repeat (2) tick;
      rst = 1'b0;
      tick;
   endtask
   task automatic setPri(input logic [5:0] n, input logic [2:0] p);
      priWr = 1'b1;
      priNum = n;
      priVal = p;
      tick;
      priWr = 1'b0;
   endtask
   task automatic req(input logic [5:0] n);
      excReq[n] = 1'b1;
      tick;
      excReq = '0;
   endtask
   task automatic finishTest;
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #40_000;
      failCount++;
      $display("watchdog expired");
      finishTest;
   end
   initial begin
      for (int i = 0; i < 6; i++) begin
         doReset;
         if (rows[i].pa != 3'h0) setPri(rows[i].a, rows[i].pa);
         if (rows[i].pb != 3'h0) setPri(rows[i].b, rows[i].pb);
         excReq[rows[i].a] = 1'b1;
         req(rows[i].b);
         chk({takeValid, takeNum}, {1'b1, rows[i].win});
         tick;
         chk(vectorAddr, {rows[i].win, 2'b00});
         repeat (3) tick;
         chk(core.handlerWord, {rows[i].win, 2'b01});
         $display("row %0d done", i);
      end
      // nesting: equal rank waits, a more urgent one cuts in
      doReset;
      lat = 4'h0;
      setPri(6'h10, 3'h3);
      setPri(6'h11, 3'h3);
      setPri(6'h12, 3'h1);
      req(6'h10);
      repeat (3) tick;
      chk(runningRank, RANK_OFS + 4'h3);
      req(6'h11);
      repeat (3) tick;
      chk({takeValid, pendingMask[17]}, 2'b01);
      lat = 4'hF;
      req(6'h12);
      chk({takeValid, takeNum}, {1'b1, 6'h12});
      lat = 4'h0;
      repeat (3) tick;
      handlerDone = 1'b1;
      tick;
      handlerDone = 1'b0;
      tick;
      chk({takeValid, runningNum, runningRank}, {1'b0, 6'h10, RANK_OFS + 4'h3});
      $display("preemption test done");
      // relocation: unprivileged, out of range, unaligned and top of range
      doReset;
      lat = 4'h1;
      for (int i = 0; i < 5; i++) begin
         relocReq = '{1'b1, rbase[i]};
         privileged = (i != 0);
         tick;
         relocReq.wr = 1'b0;
         tick;
         chk(vectorBase, rexp[i]);
      end
      req(6'h10);
      tick;
      chk(vectorAddr, 32'h3FFF_FF40);
      repeat (3) tick;
      doReset;
      chk({vectorBase, runningRank, pendingMask}, {32'h0000_0000, RANK_IDLE, 60'h0});
      $display("relocation and reset test done");
      finishTest;
   end
endmodule
